/* common/sre_defines.svh */
// shared constants for the serial eeprom read path
`ifndef SRE_DEFINES_SVH
`define SRE_DEFINES_SVH

`define SRE_ADDR_W 11
`define SRE_HI_W 3
`define SRE_BYTE_W 8
`define SRE_ERASED 8'hFF
`define SRE_DIR_READ 1'b1
`define SRE_DIR_WRITE 1'b0
`define SRE_DEV_TYPE 4'h6
`define SRE_BIT_LAST 3'h7
`define SRE_ACK_SLOT 4'h8
`define SRE_QUARTER 4
`define SRE_FIFO_DEPTH 8

`endif

/* common/sre_pkg.sv */
// types shared by both ends of the serial eeprom link
`include "sre_defines.svh"
package sre_pkg;
   typedef logic [`SRE_ADDR_W-1:0] sre_addr_t;
   typedef logic [`SRE_BYTE_W-1:0] sre_byte_t;
   typedef logic [`SRE_HI_W-1:0]   sre_hi_t;

   typedef enum logic [2:0] {
      D_IDLE     = 3'h0,
      D_RX_DEV   = 3'h1,
      D_ACK_DEV  = 3'h2,
      D_RX_WORD  = 3'h3,
      D_ACK_WORD = 3'h4,
      D_TX       = 3'h5,
      D_HOST_ACK = 3'h6,
      D_IGNORE   = 3'h7
   } sre_dev_state_e;

   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_START = 3'h1,
      H_TX    = 3'h2,
      H_RX    = 3'h3,
      H_STOP  = 3'h4
   } sre_host_state_e;

   typedef enum logic [1:0] {
      G_DEVW = 2'h0,
      G_WORD = 2'h1,
      G_DEVR = 2'h2,
      G_DATA = 2'h3
   } sre_stage_e;
endpackage : sre_pkg

/* common/sre_link_if.sv */
// two-wire link between the bus host and the eeprom read path
`timescale 1ns/1ps
interface sre_link_if;
   logic scl;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic sda;

   // open-drain wire with pull-up: any enabled low wins
   assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

   modport host (
      output scl,
      output sda_h_o,
      output sda_h_oe,
      input  sda
   );

   modport dev (
      input  scl,
      input  sda,
      output sda_d_o,
      output sda_d_oe
   );
endinterface : sre_link_if

/* logic/sre_device.sv */
// eeprom end of the read path, clocked by the link clock except start detection on sda falling and rd_evt, rd_addr and rd_data on sys_clk
`timescale 1ns/1ps
`include "sre_defines.svh"

// Operation
// - host loads address by dummy write, no stop
// - host then repeats start with read direction
// - device acknowledges read address, sends current byte
// - host not-acknowledge ends read, device releases data
// - after not-acknowledge, stop or new start accepted
// - host acknowledges bytes to keep reading
// - each acknowledge advances address, sends next byte
// - address wraps from top to zero seamlessly
// - every location reads all ones
// - three high address bits ride in device byte
// - counter keeps last address plus one
module sre_device #(
   parameter logic [3:0] DEV_TYPE = `SRE_DEV_TYPE  // arbitrary type code
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   sre_link_if.dev                   link,
   output sre_pkg::sre_byte_t        rd_data,
   output sre_pkg::sre_addr_t        rd_addr,
   output logic                      rd_evt
);
   import sre_pkg::*;

   sre_dev_state_e state;
   logic [2:0]     cnt;
   sre_byte_t      rx_sh;
   sre_byte_t      rx_byte;
   sre_byte_t      tx_sh;
   sre_addr_t      addr;
   sre_hi_t        hi;
   logic           rw_read;
   logic           start_tgl;
   logic           start_ack;
   logic           start_seen;
   logic           load;
   logic           word_done;
   logic           sda_low;
   logic           evt_tgl;
   sre_addr_t      evt_addr;
   sre_byte_t      evt_data;
   logic           evt_s1;
   logic           evt_s2;
   logic           evt_s3;
   logic           evt_seen;
   logic           evt_new;

   // array content as delivered; no write path exists here
   function automatic sre_byte_t mem_read(input sre_addr_t a);
      sre_byte_t v;
      v = `SRE_ERASED;
      if (a == '0) begin
         v = `SRE_ERASED;
      end
      return v;
   endfunction : mem_read

   // ---------------------------------------------------------------
   // start detection: sda falling while scl high
   // ---------------------------------------------------------------
   // the device only moves sda while scl is low, so its own
   // drive can never fake a start here
   always_ff @(negedge link.sda or posedge rst) begin
      if (rst) begin
         start_tgl <= 1'b0;
      end else if (link.scl) begin
         start_tgl <= ~start_tgl;
      end
   end

   // toggle settles while scl is still high, well before the
   // first address bit is clocked in
   assign start_seen = start_tgl != start_ack;
   assign rx_byte    = {rx_sh[6:0], link.sda};

   // first byte after a read-direction address, and each byte after a
   // host acknowledge, goes out from the counter value
   assign load = ~start_seen &
                 (((state == D_ACK_DEV) & rw_read) |
                  ((state == D_HOST_ACK) & ~link.sda));

   assign word_done = ~start_seen & (state == D_RX_WORD) & (cnt == `SRE_BIT_LAST);

   // ---------------------------------------------------------------
   // protocol state, sampled on the rising clock edge
   // ---------------------------------------------------------------
   always_ff @(posedge link.scl or posedge rst) begin
      if (rst) begin
         state     <= D_IDLE;
         cnt       <= 3'h0;
         rx_sh     <= 8'h00;
         hi        <= 3'h0;
         rw_read   <= 1'b0;
         start_ack <= 1'b0;
      end else begin
         start_ack <= start_tgl;
         if (start_seen) begin
            // a start, or repeated start, always restarts the frame
            state <= D_RX_DEV;
            rx_sh <= {7'h00, link.sda};
            cnt   <= 3'h1;
         end else begin
            case (state)
               D_RX_DEV: begin
                  rx_sh <= rx_byte;
                  cnt   <= cnt + 3'h1;
                  if (cnt == `SRE_BIT_LAST) begin
                     hi      <= rx_sh[2:0];
                     rw_read <= link.sda;
                     state   <= (rx_sh[6:3] == DEV_TYPE) ? D_ACK_DEV : D_IGNORE;
                  end
               end
               D_ACK_DEV: begin
                  cnt   <= 3'h0;
                  state <= rw_read ? D_TX : D_RX_WORD;
               end
               D_RX_WORD: begin
                  rx_sh <= rx_byte;
                  cnt   <= cnt + 3'h1;
                  if (cnt == `SRE_BIT_LAST) begin
                     state <= D_ACK_WORD;
                  end
               end
               D_ACK_WORD: begin
                  // data bytes of a write are not handled by this path
                  state <= D_IGNORE;
               end
               D_TX: begin
                  cnt <= cnt + 3'h1;
                  if (cnt == `SRE_BIT_LAST) begin
                     state <= D_HOST_ACK;
                  end
               end
               D_HOST_ACK: begin
                  cnt   <= 3'h0;
                  state <= link.sda ? D_IDLE : D_TX;
               end
               D_IDLE, D_IGNORE: begin
                  state <= state;
               end
               default: begin
                  state <= D_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // address counter and transmit byte
   // ---------------------------------------------------------------
   always_ff @(posedge link.scl or posedge rst) begin
      if (rst) begin
         addr  <= '0;
         tx_sh <= 8'h00;
      end else if (word_done) begin
         addr <= {hi, rx_byte};
      end else if (load) begin
         tx_sh <= mem_read(addr);
         // natural 11-bit overflow gives the wrap to zero
         addr  <= addr + 11'h001;
      end
   end

   // ---------------------------------------------------------------
   // data line drive, updated on the falling clock edge
   // ---------------------------------------------------------------
   always_ff @(negedge link.scl or posedge rst) begin
      if (rst) begin
         sda_low <= 1'b0;
      end else begin
         case (state)
            D_ACK_DEV, D_ACK_WORD: begin
               sda_low <= 1'b1;
            end
            D_TX: begin
               sda_low <= ~tx_sh[`SRE_BIT_LAST - cnt];
            end
            default: begin
               // every other state, host slot after a byte included: the line is released
               sda_low <= 1'b0;
            end
         endcase
      end
   end

   assign link.sda_d_o  = 1'b0;
   assign link.sda_d_oe = sda_low;

   // ---------------------------------------------------------------
   // hand each sent byte over to the system clock
   // ---------------------------------------------------------------
   // address and data stay put for a whole byte time, far longer
   // than the toggle needs to cross
   always_ff @(posedge link.scl or posedge rst) begin
      if (rst) begin
         evt_tgl  <= 1'b0;
         evt_addr <= '0;
         evt_data <= 8'h00;
      end else if (load) begin
         evt_tgl  <= ~evt_tgl;
         evt_addr <= addr;
         evt_data <= mem_read(addr);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         evt_s1 <= 1'b0;
         evt_s2 <= 1'b0;
         evt_s3 <= 1'b0;
      end else begin
         evt_s1 <= evt_tgl;
         evt_s2 <= evt_s1;
         evt_s3 <= evt_s2;
      end
   end

   assign evt_new = (evt_s2 == evt_s3) & (evt_s3 != evt_seen);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         evt_seen <= 1'b0;
         rd_evt   <= 1'b0;
         rd_addr  <= '0;
         rd_data  <= 8'h00;
      end else begin
         rd_evt <= evt_new;
         if (evt_new) begin
            evt_seen <= evt_s3;
            rd_addr  <= evt_addr;
            rd_data  <= evt_data;
         end
      end
   end
endmodule : sre_device

/* logic/sre_host.sv */
// bus host end: receive fifo and clock-driving read sequencer
`timescale 1ns/1ps
`include "sre_defines.svh"

module sre_fifo #(
   parameter int WIDTH = `SRE_BYTE_W,
   parameter int DEPTH = `SRE_FIFO_DEPTH
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) | (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge sys_clk) begin
      if (in_valid & in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid & in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_valid & out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule : sre_fifo

module sre_host #(
   parameter logic [3:0] DEV_TYPE = `SRE_DEV_TYPE,  // arbitrary type code
   parameter int         QUARTER  = `SRE_QUARTER
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   sre_link_if.host                  link,
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire logic                 cmd_random,
   input  wire sre_pkg::sre_addr_t   cmd_addr,
   input  wire sre_pkg::sre_byte_t   cmd_len,
   output logic                      rd_valid,
   input  wire logic                 rd_ready,
   output sre_pkg::sre_byte_t        rd_data,
   output logic                      done,
   output logic                      nack_err
);
   import sre_pkg::*;

   sre_host_state_e state;
   sre_stage_e      stage;
   logic [7:0]      div;
   logic            tick;
   logic            hold;
   logic            step;
   logic [1:0]      q;
   logic [3:0]      bitn;
   sre_byte_t       tx_sh;
   sre_byte_t       rx_sh;
   sre_byte_t       left;
   sre_addr_t       addr_l;
   logic            scl_o;
   logic            sda_low;
   logic            f_valid;
   logic            f_ready;
   logic            sda_s1;
   logic            sda_s2;
   logic            sda_s3;
   logic            sda_v;

   assign tick      = div == 8'(QUARTER - 1);
   assign f_valid   = tick & (state == H_RX) & (bitn == `SRE_ACK_SLOT) & (q == 2'h0);
   // a full fifo stretches the clock low before the ack slot
   assign hold      = f_valid & ~f_ready;
   assign step      = tick & ~hold;
   assign cmd_ready = state == H_IDLE;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div <= 8'h00;
      end else begin
         div <= tick ? 8'h00 : div + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
         sda_v  <= 1'b1;
      end else begin
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         if (sda_s2 == sda_s3) begin
            sda_v <= sda_s3;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state    <= H_IDLE;
         stage    <= G_DEVR;
         q        <= 2'h0;
         bitn     <= 4'h0;
         tx_sh    <= 8'h00;
         rx_sh    <= 8'h00;
         left     <= 8'h00;
         addr_l   <= '0;
         scl_o    <= 1'b1;
         sda_low  <= 1'b0;
         nack_err <= 1'b0;
      end else if (state == H_IDLE) begin
         if (cmd_valid) begin
            state    <= H_START;
            stage    <= cmd_random ? G_DEVW : G_DEVR;
            addr_l   <= cmd_addr;
            left     <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            q        <= 2'h0;
            nack_err <= 1'b0;
         end
      end else if (step) begin
         q <= q + 2'h1;
         case (state)
            H_START: begin
               case (q)
                  2'h0: sda_low <= 1'b0;
                  2'h1: scl_o <= 1'b1;
                  2'h2: sda_low <= 1'b1;
                  default: begin
                     scl_o <= 1'b0;
                     state <= H_TX;
                     bitn  <= 4'h0;
                     tx_sh <= {DEV_TYPE, addr_l[10:8],
                               (stage == G_DEVW) ? `SRE_DIR_WRITE : `SRE_DIR_READ};
                  end
               endcase
            end
            H_TX: begin
               case (q)
                  2'h0: sda_low <= (bitn < `SRE_ACK_SLOT) & ~tx_sh[7];
                  2'h1: scl_o <= 1'b1;
                  2'h2: scl_o <= 1'b1;
                  default: begin
                     scl_o <= 1'b0;
                     if (bitn < `SRE_ACK_SLOT) begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        bitn  <= bitn + 4'h1;
                     end else if (sda_v) begin
                        nack_err <= 1'b1;
                        state    <= H_STOP;
                     end else if (stage == G_DEVW) begin
                        stage <= G_WORD;
                        tx_sh <= addr_l[7:0];
                        bitn  <= 4'h0;
                     end else if (stage == G_WORD) begin
                        // no data byte and no stop: repeated start instead
                        stage <= G_DEVR;
                        state <= H_START;
                     end else begin
                        stage <= G_DATA;
                        state <= H_RX;
                        bitn  <= 4'h0;
                     end
                  end
               endcase
            end
            H_RX: begin
               case (q)
                  2'h0: sda_low <= (bitn == `SRE_ACK_SLOT) & (left != 8'h01);
                  2'h1: scl_o <= 1'b1;
                  2'h2: scl_o <= 1'b1;
                  default: begin
                     scl_o <= 1'b0;
                     if (bitn < `SRE_ACK_SLOT) begin
                        rx_sh <= {rx_sh[6:0], sda_v};
                        bitn  <= bitn + 4'h1;
                     end else if (left == 8'h01) begin
                        state <= H_STOP;
                     end else begin
                        left <= left - 8'h01;
                        bitn <= 4'h0;
                     end
                  end
               endcase
            end
            H_STOP: begin
               case (q)
                  2'h0: sda_low <= 1'b1;
                  2'h1: scl_o <= 1'b1;
                  2'h2: sda_low <= 1'b0;
                  default: state <= H_IDLE;
               endcase
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= step & (state == H_STOP) & (q == 2'h3);
      end
   end

   assign link.scl      = scl_o;
   assign link.sda_h_o  = 1'b0;
   assign link.sda_h_oe = sda_low;

   sre_fifo #(
      .WIDTH (`SRE_BYTE_W),
      .DEPTH (`SRE_FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (f_valid),
      .in_ready  (f_ready),
      .in_data   (rx_sh),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );
endmodule : sre_host

/* tb/sre_link_sva.sv */
// protocol checker watching the two-wire link between host and eeprom ends
`timescale 1ns/1ps
module sre_link_sva #(
   parameter logic [3:0] DEV_TYPE = 4'h6  // arbitrary type code
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda_h_o,
   input wire logic sda_h_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe,
   input wire logic sda
);
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bitn;
   logic [3:0] byten;
   logic [7:0] shreg;
   logic       rd;
   logic       dummy;
   logic       released;

   // line events as seen by oversampling on the system clock
   wire start   = scl & scl_q & sda_q & ~sda;
   wire stop    = scl & scl_q & ~sda_q & sda;
   wire rise    = scl & ~scl_q;
   wire nack_ev = rise & (bitn == 4'h8) & rd & (byten != 4'h0) & sda;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // byten saturates so a long sequential read never aliases byte 0
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bitn  <= 4'h0;
         byten <= 4'h0;
      end else if (start) begin
         bitn  <= 4'h0;
         byten <= 4'h0;
      end else if (rise) begin
         bitn  <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
         byten <= (bitn == 4'h8 && byten != 4'hF) ? byten + 4'h1 : byten;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) shreg <= 8'h00;
      else if (rise) shreg <= {shreg[6:0], sda};
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) rd <= 1'b0;
      else if (start) rd <= 1'b0;
      else if (rise && bitn == 4'h7 && byten == 4'h0) rd <= sda;
   end

   // survives the repeated start so the following address byte can be judged
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) dummy <= 1'b0;
      else if (rise && bitn == 4'h8 && byten == 4'h1 && !rd) dummy <= 1'b1;
      else if (rise && bitn == 4'h7 && byten == 4'h0) dummy <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) released <= 1'b0;
      else if (start) released <= 1'b0;
      else if (nack_ev) released <= 1'b1;
   end

   chk_dev_addr_ack:
      assert property (rise && bitn == 4'h8 && byten == 4'h0 && shreg[7:4] == DEV_TYPE |-> !sda)
         else $error("device address byte not acknowledged");
   chk_word_addr_ack:
      assert property (rise && bitn == 4'h8 && byten == 4'h1 && !rd |-> !sda)
         else $error("word address byte not acknowledged");
   chk_nack_release:
      assert property (released |-> !sda_d_oe)
         else $error("device drives data after host not-acknowledge");
   chk_data_all_ones:
      // the stop's own clock rise after a not-acknowledge carries no data bit
      assert property (rise && rd && !released && byten != 4'h0 && bitn != 4'h8 |-> sda && !sda_h_oe)
         else $error("read data bit not one");
   chk_change_scl_low:
      assert property ($changed(sda_d_oe) || $changed(sda_d_o) |-> !scl)
         else $error("device data changed while clock high");
   chk_no_dummy_data:
      assert property (!(!rd && byten == 4'h2 && (stop || (rise && bitn != 4'h0))))
         else $error("data or stop after dummy write");
   chk_read_dir_set:
      assert property (rise && bitn == 4'h7 && byten == 4'h0 && dummy |-> sda)
         else $error("address after dummy write not in read direction");
   chk_nack_then_end:
      assert property (nack_ev |-> ##[1:80] (stop || start))
         else $error("no stop or start after not-acknowledge");
endmodule : sre_link_sva

/* tb/tb_serial_eeprom_read_ops.sv */
// self-checking bench: host and eeprom ends joined by the link interface
`timescale 1ns/1ps
module tb_serial_eeprom_read_ops;
   import sre_pkg::*;
   localparam logic [3:0] DEV_CODE = 4'h6;  // arbitrary type code

   logic      sys_clk;
   logic      rst;
   logic      cmd_valid;
   logic      cmd_ready;
   logic      cmd_random;
   sre_addr_t cmd_addr;
   sre_byte_t cmd_len;
   logic      rd_valid;
   logic      rd_ready;
   sre_byte_t rd_data;
   logic      done;
   logic      nack_err;
   sre_byte_t dev_data;
   sre_addr_t dev_addr;
   logic      rd_evt;
   logic      pop_en;
   sre_addr_t ctr;
   int        err_total;
   int        comparisons;
   sre_addr_t evq[$];
   sre_byte_t got[$];

   sre_link_if sre_link_if_i ();

   sre_host #(.DEV_TYPE(DEV_CODE)) sre_host_i (
      .sys_clk(sys_clk), .rst(rst), .link(sre_link_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_random(cmd_random), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .nack_err(nack_err));

   sre_device #(.DEV_TYPE(DEV_CODE)) sre_device_i (
      .sys_clk(sys_clk), .rst(rst), .link(sre_link_if_i), .rd_data(dev_data), .rd_addr(dev_addr),
      .rd_evt(rd_evt));

   sre_link_sva #(.DEV_TYPE(DEV_CODE)) sre_link_sva_i (
      .sys_clk(sys_clk), .rst(rst), .scl(sre_link_if_i.scl), .sda_h_o(sre_link_if_i.sda_h_o),
      .sda_h_oe(sre_link_if_i.sda_h_oe), .sda_d_o(sre_link_if_i.sda_d_o),
      .sda_d_oe(sre_link_if_i.sda_d_oe), .sda(sre_link_if_i.sda));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic compare(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : compare

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up

   function automatic sre_addr_t exp_addr(input sre_addr_t base, input int i);
      return base + sre_addr_t'(i);
   endfunction : exp_addr

   // the head is recorded when the pop is decided, so the next edge takes exactly it
   always @(negedge sys_clk) begin
      if (rd_evt === 1'b1) begin
         evq.push_back(dev_addr);
         compare("dev_data", 16'(dev_data), 16'hFF);
      end
      if (pop_en && $urandom_range(3) != 0) begin
         rd_ready <= 1'b1;
         if (rd_valid === 1'b1) got.push_back(rd_data);
      end else begin
         rd_ready <= 1'b0;
      end
   end

   task automatic run_cmd(input logic rnd, input sre_addr_t addr, input sre_byte_t len, input logic stall);
      int        n;
      int        i;
      sre_addr_t base;
      logic      seen_done;
      n = (len == 8'h00) ? 1 : int'(len);
      base = rnd ? addr : ctr;
      pop_en = ~stall;
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_random = rnd;
      cmd_addr = addr;
      cmd_len = len;
      i = 0;
      while (cmd_ready !== 1'b1 && i < 100) begin
         @(negedge sys_clk);
         i++;
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      if (stall) begin
         // full receive buffer must freeze the link before the tenth byte
         repeat (3000) @(negedge sys_clk);
         compare("stall_events", 16'(evq.size()), 16'd9);
         compare("stall_busy", 16'(cmd_ready), 16'h0);
         pop_en = 1'b1;
      end
      seen_done = 1'b0;
      i = 0;
      while (!seen_done && i < 20000) begin
         @(negedge sys_clk);
         seen_done = (done === 1'b1);
         i++;
      end
      compare("done", 16'(seen_done), 16'h1);
      pop_en = 1'b1;
      i = 0;
      while (rd_valid === 1'b1 && i < 200) begin
         @(negedge sys_clk);
         i++;
      end
      compare("event_count", 16'(evq.size()), 16'(n));
      compare("byte_count", 16'(got.size()), 16'(n));
      for (i = 0; i < n && i < evq.size(); i++) begin
         compare("event_addr", 16'(evq[i]), 16'(exp_addr(base, i)));
      end
      for (i = 0; i < got.size(); i++) begin
         compare("host_byte", 16'(got[i]), 16'hFF);
      end
      compare("nack_err", 16'(nack_err), 16'h0);
      ctr = exp_addr(base, n);
      evq.delete();
      got.delete();
   endtask : run_cmd

   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_random = 1'b0;
      cmd_addr = 11'h000;
      cmd_len = 8'h00;
      rd_ready = 1'b0;
      pop_en = 1'b1;
      ctr = 11'h000;
      err_total = 0;
      comparisons = 0;
      void'($urandom(12));
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      run_cmd(1'b0, 11'h555, 8'h03, 1'b0);
      run_cmd(1'b1, 11'h7FE, 8'h04, 1'b0);
      run_cmd(1'b0, 11'h123, 8'h02, 1'b0);
      run_cmd(1'b1, 11'h5A3, 8'h0C, 1'b1);
      run_cmd(1'b1, 11'h7FF, 8'h00, 1'b0);
      for (int k = 0; k < 8; k++) begin
         run_cmd(1'($urandom_range(1)), sre_addr_t'($urandom), 8'($urandom_range(10, 1)), 1'b0);
      end
      // a second reset returns the counter to location zero
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      ctr = 11'h000;
      run_cmd(1'b0, 11'h3FF, 8'h02, 1'b0);
      run_cmd(1'b1, 11'h4F0, 8'h01, 1'b0);
      wrap_up();
   end

   initial begin
      // about 50,000 clocks: more than twice the length of a clean run
      #2000000;
      err_total++;
      $display("Error watchdog expected finish seen hang");
      wrap_up();
   end
endmodule : tb_serial_eeprom_read_ops
